// >>> reply_pulse_train_encoder_tb_top.sv
// bench: axi-lite master, random replies, ident, aborts, lockout
// drives rpte_core and the partner model; the checker is bound
`include "rpte_regs.vh"
module reply_pulse_train_encoder_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = '0, aresetn = '0, ident_sw = '0, ext_suppress = '0;
    logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
    logic s_axi_arvalid = '0, s_axi_rready = '0;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, v, seed = 32'h20;
    logic [11:0] alt_code = '0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [5:0] desense_db, sens_reduce_db, smax;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, tx_pulse, reply_busy, lockout, p3_lead, mode_c;
    logic rx_video;
    logic [17:0] heard;
    int err_total = 0, num_checks = 0;
    int rt[3] = '{1200, 1000, 600};
    always #5 aclk = ~aclk;
    rpte_core #(.IDENT_HOLD_CYC(32'd8000), .RATE_WIN_CYC(32'd1000),
        .WIN_PER_SEC(32'd1000), .LOCK_MAX_CYC(32'd200),
        .LOCK_REST_CYC(32'd4300)) rpte_core_inst (.aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .rx_video, .p3_lead, .mode_c, .alt_code, .ident_sw,
        .ext_suppress, .tx_pulse, .desense_db, .sens_reduce_db,
        .reply_busy, .lockout);
    rpte_partner rpte_partner_inst (.aclk, .tx_pulse, .p3_lead, .mode_c,
        .rx_video, .got(heard));
    // peak rate cut seen since the last third pulse
    always @(posedge aclk)
        smax <= p3_lead ? 6'h00
            : (sens_reduce_db > smax ? sens_reduce_db : smax);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // expected slots: framing, code order, spare empty, ident
    function automatic logic [17:0] exp_map(logic [11:0] c, logic s);
        int idx[13] = '{6, 0, 7, 1, 8, 2, -1, 3, 9, 4, 10, 5, 11};
        exp_map = 18'h04001 | {s, 17'h00000};
        for (int k = 0; k < 13; k++)
            if (idx[k] >= 0) exp_map[k + 1] = c[idx[k]];
    endfunction
    // one reply per 1000-cycle window is 1000 per second
    function automatic logic [5:0] exp_sens(int r);
        return 10000 <= r * 9 ? 6'h00 : (2000 >= r * 3 ? 6'h28 : 6'h0F);
    endfunction
    task automatic chk(logic [33:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // bounded wait for a level at a rising edge
    task automatic until_is(ref logic s, input logic lv);
        for (int n = 0; n < 20000 && s !== lv; n++)
            @(posedge aclk);
        if (s !== lv) begin
            err_total++;
            complete_run();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        @(posedge aclk);
        until_is(s_axi_awready, 1'b1);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_bready <= 1'b1;
        @(posedge aclk);
        until_is(s_axi_bvalid, 1'b1);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, logic [31:0] e, logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        @(posedge aclk);
        until_is(s_axi_arready, 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        until_is(s_axi_rvalid, 1'b1);
        s_axi_rready <= 1'b0;
        chk({s_axi_rresp, s_axi_rdata}, {r, e});
    endtask
    // interrogate, optionally echo in the delay, check slots and rate cut
    task automatic reply(logic m, logic [17:0] e, int r, int ew);
        wr(`RPTE_OFS_RATE, r);
        rpte_partner_inst.ask(m);
        if (ew > 0) rpte_partner_inst.echo(ew);
        repeat (2940) @(posedge aclk);
        until_is(reply_busy, 1'b0);
        chk(heard, e);
        chk(smax, e == 0 ? 6'h00 : exp_sens(r));
    endtask
    task automatic press();
        ident_sw <= 1'b1;
        repeat (4) @(posedge aclk);
        ident_sw <= 1'b0;
    endtask
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`RPTE_OFS_CTRL, `RPTE_CTRL_RST, 2'h0);
        rd(`RPTE_OFS_RATE, `RPTE_RATE_RST, 2'h0);
        rd(8'h20, 32'h0, 2'h2);
        s_axi_wstrb <= 4'h1;
        wr(`RPTE_OFS_CODE, 32'h0000_0ABC);
        s_axi_wstrb <= 4'hF;
        rd(`RPTE_OFS_CODE, 32'h0000_00BC, 2'h0);
        wr(`RPTE_OFS_RATE, 32'd100);
        rd(`RPTE_OFS_RATE, `RPTE_RATE_MIN, 2'h0);
        wr(`RPTE_OFS_RATE, 32'd5000);
        rd(`RPTE_OFS_RATE, `RPTE_RATE_MAX, 2'h0);
        for (int i = 0; i < 6; i++) begin
            v = i == 0 ? 32'hFFFFFFFF : (i == 1 ? 32'h0 : rnd());
            alt_code <= v[27:16];
            wr(`RPTE_OFS_CODE, {20'h0, v[11:0]});
            reply(v[12], exp_map(v[12] ? v[27:16] : v[11:0], 1'b0),
                rt[i % 3], 0);
        end
        wr(`RPTE_OFS_CTRL, 32'h3);
        reply(1'b1, 18'h04001, 1200, 0);
        wr(`RPTE_OFS_CTRL, 32'h0);
        reply(1'b0, 18'h00000, 1200, 0);
        wr(`RPTE_OFS_CTRL, 32'h1);
        reply(1'b0, 18'h00000, 1200, 10);
        chk(desense_db, 6'h00);
        reply(1'b0, 18'h00000, 1200, 160);
        wr(`RPTE_OFS_CODE, 32'h0);
        alt_code <= 12'h000;
        press();
        reply(1'b1, 18'h04001, 1200, 0);
        press();
        repeat (4000) @(posedge aclk);
        reply(1'b0, 18'h24001, 1200, 0);
        repeat (9000) @(posedge aclk);
        reply(1'b0, 18'h04001, 1200, 0);
        rpte_partner_inst.echo(100);
        repeat (2) @(posedge aclk);
        chk(desense_db, 6'd45);
        repeat (1500) @(posedge aclk);
        chk(desense_db, 6'h00);
        ext_suppress <= 1'b1;
        repeat (10) @(posedge aclk);
        chk(lockout, 1'b1);
        reply(1'b0, 18'h00000, 1200, 0);
        chk(lockout, 1'b0);
        ext_suppress <= 1'b0;
        complete_run();
    end
endmodule // reply_pulse_train_encoder_tb_top

// >>> rpte_chk.sv
// checker: slot grid, key width, dead time, lockout, desense
// sees only core ports; the bind statement follows the module
module rpte_chk #(
    parameter LOCK_MAX_CYC = 200 // lockout cap in cycles
) (
    input wire aclk, // clock
    input wire aresetn, // reset, active low
    input wire p3_lead, // third pulse edge
    input wire mode_c, // altitude mode
    input wire tx_pulse, // transmitter key
    input wire [5:0] desense_db, // desense level
    input wire reply_busy, // reply or dead time
    input wire lockout // lockout active
);
    logic [15:0] t; // cycles into reply
    logic [7:0] w; // cycles key held
    logic [17:0] lc; // cycles locked out
    logic f1; // first framing seen
    logic mc; // mode of this reply
    // helper counters, cleared by reset
    always @(posedge aclk) begin
        t <= (!aresetn || !reply_busy) ? 16'h0000 : t + 16'h0001;
        w <= (!aresetn || !tx_pulse) ? 8'h00 : w + 8'h01;
        lc <= (!aresetn || !lockout) ? 18'h00000 : lc + 18'h00001;
        f1 <= aresetn && reply_busy && (f1 || (tx_pulse && t == 16'd300));
        if (p3_lead && !reply_busy)
            mc <= mode_c;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_key_up; $rose(tx_pulse); endsequence
    property p_grid; s_key_up |-> t >= 300 && (t - 300) % 145 == 0; endproperty
    a_grid: assert property (p_grid)
        else $error("key rose off the slot grid");
    property p_width; $fell(tx_pulse) |-> w == 8'd45; endproperty
    a_width: assert property (p_width)
        else $error("key width wrong");
    property p_frame; f1 && t == 16'd2330 |-> s_key_up; endproperty
    a_frame: assert property (p_frame)
        else $error("second framing pulse missing");
    property p_xslot; t >= 1315 && t < 1460 |-> !tx_pulse; endproperty
    a_xslot: assert property (p_xslot)
        else $error("spare slot not empty");
    property p_spi; s_key_up ##0 t == 16'd2765 |-> !mc; endproperty
    a_spi: assert property (p_spi)
        else $error("ident pulse on altitude reply");
    property p_dead; reply_busy |-> t <= 16'd15410; endproperty
    a_dead: assert property (p_dead)
        else $error("dead time too long");
    property p_lock; lockout |-> lc <= LOCK_MAX_CYC; endproperty
    a_lock: assert property (p_lock)
        else $error("lockout too long");
    property p_des;
        $changed(desense_db) |-> desense_db == 6'd45
            || desense_db == $past(desense_db) - 6'd3;
    endproperty
    a_des: assert property (p_des)
        else $error("desense step wrong");
endmodule // rpte_chk
bind rpte_core rpte_chk #(.LOCK_MAX_CYC(LOCK_MAX_CYC)) rpte_chk_inst (
    .aclk, .aresetn, .p3_lead, .mode_c, .tx_pulse, .desense_db,
    .reply_busy, .lockout);

// >>> rpte_core.v
// reply timing and pulse train encoder with its axi4-lite register slave
// assumes p3_lead, mode_c, alt_code are on aclk;
// rx_video, ident_sw, ext_suppress are pins, synchronised here
`include "rpte_regs.vh"

// Contract
// - framing pair 20.3 us apart
// - code slots on 1.45 us pitch
// - code slot order C1 first, D4 last
// - slot X stays empty
// - all 4096 codes sendable
// - ident pulse 4.35 us after last framing
// - no ident pulse in altitude mode
// - ident pulse held 15 to 30 s
// - each pulse lasts 0.45 us
// - first pulse 3 us after third
// - reply jitter within 0.1 us
// - same delay in every mode
// - dead time ends within 125 us
// - other lockout capped, low duty
// - too short or long pulses ignored
// - pulse over 0.7 us desenses
// - desense recovers linearly within 15 us
// - rate limit 500 to 2000
// - cut starts above 90, full by 150
// - rate limit defaults to 1200
// - sustains 1200 replies per second
// - altitude reply keeps framing
// - each pulse within 0.1 us of nominal
module rpte_core #(
    parameter IDENT_HOLD_CYC = 32'd2000000000, // 20 s of spi enable
    parameter RATE_WIN_CYC = 32'd1000000, // 10 ms rate window
    parameter WIN_PER_SEC = 32'd100, // windows in one second
    parameter LOCK_MAX_CYC = 32'd250000, // 2500 us lockout cap
    parameter LOCK_REST_CYC = 32'd5306000 // rest after a capped lockout
) (
    input wire aclk, // system clock, 100 mhz
    input wire aresetn, // synchronous reset, active low
    input wire [7:0] s_axi_awaddr, // write address
    input wire s_axi_awvalid, // write address valid
    output wire s_axi_awready, // write address ready
    input wire [31:0] s_axi_wdata, // write data
    input wire [3:0] s_axi_wstrb, // write byte enables
    input wire s_axi_wvalid, // write data valid
    output wire s_axi_wready, // write data ready
    output reg [1:0] s_axi_bresp, // write response
    output reg s_axi_bvalid, // write response valid
    input wire s_axi_bready, // write response ready
    input wire [7:0] s_axi_araddr, // read address
    input wire s_axi_arvalid, // read address valid
    output wire s_axi_arready, // read address ready
    output reg [31:0] s_axi_rdata, // read data
    output reg [1:0] s_axi_rresp, // read response
    output reg s_axi_rvalid, // read data valid
    input wire s_axi_rready, // read data ready
    input wire rx_video, // receiver video pin
    input wire p3_lead, // decoder: third pulse leading edge
    input wire mode_c, // decoder: interrogation is altitude mode
    input wire [11:0] alt_code, // altitude code from the digitiser
    input wire ident_sw, // identification switch pin
    input wire ext_suppress, // suppression from other equipment
    output reg tx_pulse, // reply transmitter key
    output reg [5:0] desense_db, // echo desensitisation level
    output reg [5:0] sens_reduce_db, // rate-control sensitivity cut
    output reg reply_busy, // reply or dead time in progress
    output reg lockout // external lockout active
);
    // one-hot reply sequencer states
    localparam ST_IDLE = 4'b0001;
    localparam ST_DELAY = 4'b0010;
    localparam ST_SEND = 4'b0100;
    localparam ST_DEAD = 4'b1000;

    reg [31:0] ctrl, rate_lim, reply_cnt; // control, rate limit, replies
    reg [11:0] code, use_code; // identity code, code of this reply
    reg [3:0] state, next_state; // sequencer state and next state
    reg [11:0] tcnt; // delay, phase and dead time counter
    reg [4:0] slot; // current slot of the train
    reg [`RPTE_NSLOT-1:0] train, next_train; // slot pattern, sent and built
    reg spi_en, lock_rest; // ident pulse this reply; lockout resting
    reg [31:0] ident_cnt, lock_cnt; // ident hold and lockout timers
    reg id_a, id_b, id_c; // ident sync stages and edge delay
    reg sp_a, sp_b; // suppression synchroniser stages
    reg [6:0] us_cnt; // microsecond divider for recovery
    reg [31:0] win_cnt, win_replies, meas_rate; // rate window and result
    wire [31:0] wr_data; // merged write data
    wire pulse_short, pulse_long, desense_hit; // filter width events
    wire wr_go, trig, ident_rise; // write taken, trigger, ident press

    // width discriminator on the receiver video
    rpte_pulse_filter #(.CW(8)) u_filter (
        .aclk(aclk),
        .aresetn(aresetn),
        .rx_video(rx_video),
        .pulse_short(pulse_short),
        .pulse_long(pulse_long),
        .desense_hit(desense_hit)
    );

    // write address and data are taken together when both are offered
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_arready = !s_axi_rvalid;

    // byte-lane merge of the write data into a register value
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] strb;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1)
                if (strb[i])
                    merge[i*8 +: 8] = nw[i*8 +: 8];
        end
    endfunction

    // register writes and the write response
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= `RPTE_CTRL_RST;
            code <= 12'h000;
            rate_lim <= `RPTE_RATE_RST;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else begin
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'b00;
                case (s_axi_awaddr)
                    `RPTE_OFS_CTRL: ctrl <= merge(ctrl, s_axi_wdata,
                        s_axi_wstrb) & 32'h0000_0003;
                    `RPTE_OFS_CODE: code <= wr_data[11:0];
                    `RPTE_OFS_RATE: rate_lim <= (wr_data < `RPTE_RATE_MIN) ?
                        `RPTE_RATE_MIN : (wr_data > `RPTE_RATE_MAX) ?
                        `RPTE_RATE_MAX : wr_data;
                    `RPTE_OFS_STAT, `RPTE_OFS_CNT: ; // read-only
                    default: s_axi_bresp <= 2'b10; // unmapped
                endcase
            end
        end
    end

    // merged value for the code and rate registers
    assign wr_data = merge(s_axi_awaddr == `RPTE_OFS_CODE ?
        {20'h00000, code} : rate_lim, s_axi_wdata, s_axi_wstrb);

    // register reads
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end else if (s_axi_arvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            case (s_axi_araddr)
                `RPTE_OFS_CTRL: s_axi_rdata <= ctrl;
                `RPTE_OFS_CODE: s_axi_rdata <= {20'h00000, code};
                `RPTE_OFS_RATE: s_axi_rdata <= rate_lim;
                `RPTE_OFS_STAT: s_axi_rdata <= {12'h000, sens_reduce_db,
                    2'b00, desense_db, 2'b00, spi_en, lockout, reply_busy};
                `RPTE_OFS_CNT: s_axi_rdata <= reply_cnt;
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'b10; // unmapped
                end
            endcase
        end
    end

    // pin synchronisers for the ident switch and external suppression
    always @(posedge aclk) begin
        if (!aresetn) begin
            id_a <= 1'b0;
            id_b <= 1'b0;
            id_c <= 1'b0;
            sp_a <= 1'b0;
            sp_b <= 1'b0;
        end else begin
            id_a <= ident_sw;
            id_b <= id_a;
            id_c <= id_b;
            sp_a <= ext_suppress;
            sp_b <= sp_a;
        end
    end
    assign ident_rise = id_b && !id_c;

    // ident hold timer; every press reloads the full period
    always @(posedge aclk) begin
        if (!aresetn)
            ident_cnt <= 32'h0;
        else if (ident_rise)
            ident_cnt <= IDENT_HOLD_CYC;
        else if (ident_cnt != 32'h0)
            ident_cnt <= ident_cnt - 32'd1;
    end

    // external lockout, capped in length then rested to bound duty
    always @(posedge aclk) begin
        if (!aresetn) begin
            lockout <= 1'b0;
            lock_rest <= 1'b0;
            lock_cnt <= 32'h0;
        end else if (lock_rest) begin
            lockout <= 1'b0;
            if (lock_cnt == 32'h0)
                lock_rest <= 1'b0;
            else
                lock_cnt <= lock_cnt - 32'd1;
        end else if (sp_b) begin
            if (lock_cnt == LOCK_MAX_CYC - 32'd1) begin
                lockout <= 1'b0;
                lock_rest <= 1'b1;
                lock_cnt <= LOCK_REST_CYC;
            end else begin
                lockout <= 1'b1;
                lock_cnt <= lock_cnt + 32'd1;
            end
        end else begin
            lockout <= 1'b0;
            lock_cnt <= 32'h0;
        end
    end

    // only an idle, enabled, unlocked encoder accepts a trigger
    assign trig = p3_lead && state == ST_IDLE && !lockout
        && ctrl[`RPTE_CTRL_EN];

    // build the slot pattern at trigger time
    always @* begin
        use_code = mode_c ? (ctrl[`RPTE_CTRL_ALT_OFF] ? 12'h000 : alt_code)
            : code;
        next_train = {`RPTE_NSLOT{1'b0}};
        next_train[0] = 1'b1;
        next_train[`RPTE_SLOT_F2] = 1'b1;
        next_train[1] = use_code[`RPTE_C1];
        next_train[2] = use_code[`RPTE_A1];
        next_train[3] = use_code[`RPTE_C2];
        next_train[4] = use_code[`RPTE_A2];
        next_train[5] = use_code[`RPTE_C4];
        next_train[6] = use_code[`RPTE_A4];
        next_train[7] = 1'b0;
        next_train[8] = use_code[`RPTE_B1];
        next_train[9] = use_code[`RPTE_D1];
        next_train[10] = use_code[`RPTE_B2];
        next_train[11] = use_code[`RPTE_D2];
        next_train[12] = use_code[`RPTE_B4];
        next_train[13] = use_code[`RPTE_D4];
        next_train[`RPTE_SLOT_SPI] = (ident_cnt != 32'h0000_0000)
            && !mode_c;
    end

    // sequencer next state
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: if (trig) next_state = ST_DELAY;
            ST_DELAY: begin
                // the third pulse proved too narrow or too wide
                if (pulse_short || pulse_long)
                    next_state = ST_IDLE;
                else if (tcnt == `RPTE_DELAY_CYC - 1)
                    next_state = ST_SEND;
            end
            ST_SEND: if (slot == `RPTE_NSLOT - 1 && tcnt == `RPTE_SLOT_CYC - 1)
                next_state = ST_DEAD;
            ST_DEAD: if (tcnt == `RPTE_DEAD_CYC - 1) next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    // sequencer registers, slot timing and the transmitter key
    always @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_IDLE;
            tcnt <= 12'h000;
            slot <= 5'h00;
            train <= {`RPTE_NSLOT{1'b0}};
            spi_en <= 1'b0;
            tx_pulse <= 1'b0;
            reply_busy <= 1'b0;
            reply_cnt <= 32'h0000_0000;
        end else begin
            state <= next_state;
            reply_busy <= next_state != ST_IDLE;
            if (next_state != state)
                tcnt <= 12'h000;
            else if (state == ST_SEND && tcnt == `RPTE_SLOT_CYC - 1)
                tcnt <= 12'h000;
            else
                tcnt <= tcnt + 12'h001;
            if (trig) begin
                train <= next_train;
                spi_en <= next_train[`RPTE_SLOT_SPI];
            end
            // key is high for the first part of each occupied slot
            if (next_state == ST_SEND && state == ST_DELAY) begin
                slot <= 5'h00;
                reply_cnt <= reply_cnt + 32'd1;
                tx_pulse <= train[0];
            end else if (state == ST_SEND) begin
                if (tcnt == `RPTE_SLOT_CYC - 1) begin
                    slot <= slot + 5'h01;
                    tx_pulse <= slot != `RPTE_NSLOT - 1
                        && train[slot + 5'h01];
                end else if (tcnt == `RPTE_WIDTH_CYC - 1)
                    tx_pulse <= 1'b0;
            end else
                tx_pulse <= 1'b0;
        end
    end

    // echo desensitisation with linear recovery of 3 db per microsecond
    always @(posedge aclk) begin
        if (!aresetn) begin
            desense_db <= 6'h00;
            us_cnt <= 7'h00;
        end else if (desense_hit) begin
            desense_db <= `RPTE_DES_INIT;
            us_cnt <= 7'h00;
        end else if (desense_db != 6'h00) begin
            if (us_cnt == `RPTE_US_CYC - 1) begin
                us_cnt <= 7'h00;
                desense_db <= (desense_db > `RPTE_DES_STEP) ?
                    desense_db - `RPTE_DES_STEP : 6'h00;
            end else
                us_cnt <= us_cnt + 7'h01;
        end
    end

    // reply rate measured over a window, scaled to replies per second
    always @(posedge aclk) begin
        if (!aresetn) begin
            win_cnt <= 32'h0;
            win_replies <= 32'h0;
            meas_rate <= 32'h0;
        end else if (win_cnt == RATE_WIN_CYC - 32'd1) begin
            win_cnt <= 32'h0;
            meas_rate <= win_replies * WIN_PER_SEC;
            win_replies <= 32'h0;
        end else begin
            win_cnt <= win_cnt + 32'd1;
            if (state == ST_DELAY && next_state == ST_SEND)
                win_replies <= win_replies + 32'd1;
        end
    end

    // sensitivity reduction steps against the selected limit
    always @(posedge aclk) begin
        if (!aresetn)
            sens_reduce_db <= 6'h00;
        else if (meas_rate * 32'd10 <= rate_lim * 32'd9)
            sens_reduce_db <= 6'h00;
        else if (meas_rate * 32'd2 >= rate_lim * 32'd3)
            sens_reduce_db <= `RPTE_SENS_MAX;
        else
            sens_reduce_db <= `RPTE_SENS_MID;
    end
endmodule // rpte_core

// >>> rpte_partner.sv
// interrogator side: third pulse, echo video, reply slot decoder
// drives just after rising edges; reads each slot mid-pulse
module rpte_partner (
    input wire aclk, // clock
    input wire tx_pulse, // transmitter key
    output logic p3_lead = 1'b0, // third pulse edge
    output logic mode_c = 1'b0, // altitude mode
    output logic rx_video = 1'b0, // receiver video
    output logic [17:0] got // slots heard in last reply
);
    logic [15:0] c; // cycles since third pulse
    // slot k sampled 22 cycles into its pulse
    always @(posedge aclk) begin
        c <= p3_lead ? 16'h0000 : c + 16'h0001;
        if (p3_lead)
            got <= 18'h00000;
        else if (c >= 322 && c < 2932 && (c - 322) % 145 == 0)
            got[(c - 322) / 145] <= tx_pulse;
    end
    // one interrogation; mode line flips once released
    task automatic ask(input logic m);
        p3_lead <= 1'b1;
        mode_c <= m;
        @(posedge aclk);
        p3_lead <= 1'b0;
        mode_c <= ~m;
    endtask
    // one video pulse of n cycles
    task automatic echo(input int n);
        rx_video <= 1'b1;
        repeat (n) @(posedge aclk);
        rx_video <= 1'b0;
    endtask
endmodule // rpte_partner

// >>> rpte_pulse_filter.v
// pulse width discriminator for the receiver video input
// assumes rx_video is asynchronous to aclk
`include "rpte_regs.vh"

module rpte_pulse_filter #(
    parameter CW = 8 // width counter bits
) (
    input wire aclk, // system clock
    input wire aresetn, // synchronous reset, active low
    input wire rx_video, // raw detected video pulse
    output reg pulse_short, // pulse ended shorter than the low limit
    output reg pulse_long, // pulse grew past the high limit
    output reg desense_hit // pulse reached the desense width
);
    reg sync_a; // first synchroniser stage
    reg sync_b; // second synchroniser stage
    reg [CW-1:0] width; // cycles the pulse has lasted

    // two-stage synchroniser; only sync_b is read
    always @(posedge aclk) begin
        if (!aresetn) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
        end else begin
            sync_a <= rx_video;
            sync_b <= sync_a;
        end
    end

    // width counting and the three width events
    always @(posedge aclk) begin
        if (!aresetn) begin
            width <= {CW{1'b0}};
            pulse_short <= 1'b0;
            pulse_long <= 1'b0;
            desense_hit <= 1'b0;
        end else begin
            pulse_short <= 1'b0;
            pulse_long <= 1'b0;
            desense_hit <= 1'b0;
            if (sync_b) begin
                // saturate so a long pulse never wraps
                if (width != {CW{1'b1}})
                    width <= width + 1'b1;
                if (width == `RPTE_DES_CYC - 1)
                    desense_hit <= 1'b1;
                if (width == `RPTE_LONG_CYC)
                    pulse_long <= 1'b1;
            end else begin
                // trailing edge of a pulse too narrow to act on
                if (width != {CW{1'b0}} && width < `RPTE_SHORT_CYC)
                    pulse_short <= 1'b1;
                width <= {CW{1'b0}};
            end
        end
    end
endmodule // rpte_pulse_filter

// >>> rpte_regs.vh
// constants of the reply pulse train encoder: offsets, fields, timing
// assumes a 100 MHz aclk: cycle counts are of its 10 ns period
`ifndef RPTE_REGS_VH
`define RPTE_REGS_VH

// register byte offsets on the axi4-lite slave
`define RPTE_OFS_CTRL 8'h00
`define RPTE_OFS_CODE 8'h04
`define RPTE_OFS_RATE 8'h08
`define RPTE_OFS_STAT 8'h0C
`define RPTE_OFS_CNT 8'h10

// control register fields
`define RPTE_CTRL_EN 0
`define RPTE_CTRL_ALT_OFF 1
`define RPTE_CTRL_RST 32'h1

// code word layout: a1 a2 a4, b1 b2 b4, c1 c2 c4, d1 d2 d4
`define RPTE_A1 0
`define RPTE_A2 1
`define RPTE_A4 2
`define RPTE_B1 3
`define RPTE_B2 4
`define RPTE_B4 5
`define RPTE_C1 6
`define RPTE_C2 7
`define RPTE_C4 8
`define RPTE_D1 9
`define RPTE_D2 10
`define RPTE_D4 11

// rate limit in replies per second, legal range and reset value
`define RPTE_RATE_MIN 32'd500
`define RPTE_RATE_MAX 32'd2000
`define RPTE_RATE_RST 32'd1200

// timing in 10 ns cycles: slot, width, delay, filter, desense, us, dead
`define RPTE_SLOT_CYC 145
`define RPTE_WIDTH_CYC 45
`define RPTE_DELAY_CYC 300
`define RPTE_SHORT_CYC 30
`define RPTE_LONG_CYC 150
`define RPTE_DES_CYC 70
`define RPTE_US_CYC 100
`define RPTE_DEAD_CYC 2000

// slot numbers: framing pair at 0 and 14, special pulse at 17
`define RPTE_SLOT_F2 14
`define RPTE_SLOT_SPI 17
`define RPTE_NSLOT 18

// desensitisation start level and recovery step, in db
`define RPTE_DES_INIT 6'd45
`define RPTE_DES_STEP 6'd3
// sensitivity reduction levels in db
`define RPTE_SENS_MID 6'd15
`define RPTE_SENS_MAX 6'd40

`endif
